/* File: core/part_track_map.svh */
// offsets, field positions, reset values and timing counts of the tracking block
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef PART_TRACK_MAP_SVH
`define PART_TRACK_MAP_SVH
// -----------------------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------------------
`define ADDR_CONFIG     8'h00
`define ADDR_POWER      8'h04
`define ADDR_POWER_ADJ  8'h08
`define ADDR_MOTION     8'h0c
`define ADDR_TRIM       8'h10
`define ADDR_SENSOR_OFS 8'h14
`define ADDR_RESOLUTION 8'h18
`define ADDR_LINE_SPEED 8'h1c
`define ADDR_RASTER_DLY 8'h20
`define ADDR_POSITION   8'h24
`define ADDR_STATUS     8'h28
`define ADDR_MASK       8'h2c
`define ADDR_CONTROL    8'h30
`define ADDR_DISTANCE   8'h34
// -----------------------------------------------------------------------------
// config fields
// -----------------------------------------------------------------------------
`define CFG_INTERLOCK_EN 0
`define CFG_PWM_MODE     1
`define CFG_OUT_REMAP    2
`define CFG_RISING_EDGE  3
`define CFG_QUADRATURE   4
`define CFG_INVERT_DIR   5
`define CFG_ENCODERLESS  6
`define CFG_HOST_OUT     7
`define CFG_RESET        8'h02
// -----------------------------------------------------------------------------
// control fields (mark done and raster go act on write one; laser req holds the written level)
// -----------------------------------------------------------------------------
`define CTL_MARK_DONE  0
`define CTL_RASTER_GO  1
`define CTL_LASER_REQ  2
// -----------------------------------------------------------------------------
// status bits
// -----------------------------------------------------------------------------
`define ST_PART_START  0
`define ST_MISSED      1
`define ST_RASTER_DONE 2
`define ST_MARK_START  3
// -----------------------------------------------------------------------------
// reset values and limits
// -----------------------------------------------------------------------------
`define POWER_ADJ_RESET 16'd1000
`define POWER_ADJ_UNITY 16'd1000
`define MOTION_MAX      16'd359
`define TRIM_LIMIT      16'sd1500
`define RESOLUTION_RESET 16'h0001
`define DEBOUNCE_NS     40
`define CLK_PERIOD_NS   5
`define DEBOUNCE_CYCLES ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWM_PERIOD      12'hfff
`define RATE_TICK_NS    1000
`define RATE_TICK_CYCLES (`RATE_TICK_NS / `CLK_PERIOD_NS)
`endif

/* File: core/part_track_pkg.sv */
// types shared by the tracking block
// assumes part_track_map.svh holds the numbers
package part_track_pkg;
  typedef struct packed {
    logic phaseA;
    logic phaseB;
    logic partSense;
    logic interlockInput;
    logic overTemp;
  } pins_in_t;

  typedef struct packed {
    logic laserOut;
    logic configurableOutput;
  } pins_out_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] datW;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_t;

  typedef enum logic [1:0] {
    RASTER_IDLE   = 2'b00,
    RASTER_SETTLE = 2'b01,
    RASTER_OUT    = 2'b11
  } raster_state_t;
endpackage : part_track_pkg

/* File: core/part_tracking_encoder_control.sv */
// part tracking, encoder decode and laser gating control of a marking head
// assumes a classic wishbone master on core_clk; pins are asynchronous
// Function
// - with interlock enabled, laser fires only while interlock input is high
// - gate mode drives laser fully on or off; pwm mode modulates duty
// - remap off: configurable output follows host output commands only
// - remap on: host ignored, output shows over-temperature warning
// - commanded power is scaled by global percentage, default 100%
// - motion direction in degrees: 0 right, 90 down, 180 left, 270 up
// - angle trim in 0.0001 degree steps, limited to plus or minus 0.15
// - mark starts on rising sensor edge if selected, else falling edge
// - quadrature gives direction and count; else single pulse counts forward
// - counts convert to distance with resolution in pulses per millimetre
// - direction invert swaps the two quadrature phases
// - encoderless off: position follows external encoder input
// - encoderless on: position advances at fixed programmed line speed
// - trigger during a mark in progress raises a missed-start error
// - mark leading edge placed at sensor offset from window centreline
// - each raster line waits a programmable settling delay before output
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "part_track_map.svh"
module part_tracking_encoder_control (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire part_track_pkg::wb_req_t wbReq,
  output logic [31:0]                 wbDatR,
  output logic                        wbAck,
  input  wire part_track_pkg::pins_in_t pinsIn,
  output part_track_pkg::pins_out_t   pinsOut,
  output logic                        markStart,
  output logic                        rasterOut,
  output logic                        irq
);
  import part_track_pkg::*;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [7:0]         config_;
  logic [15:0]        power;
  logic [15:0]        powerAdj;
  logic [15:0]        motion;
  logic signed [15:0] trim;
  logic [31:0]        sensorOfs;
  logic [15:0]        resolution;
  logic [15:0]        lineSpeed;
  logic [15:0]        rasterDly;
  logic signed [31:0] position;
  logic [3:0]         status;
  logic [3:0]         mask;
  logic               markBusy;
  logic [31:0]        distance;
  logic signed [31:0] startPos;
  logic               partEdge;

  logic wrStb;
  logic rdStb;
  logic ctlWr;
  assign wrStb = wbReq.cyc & wbReq.stb & wbReq.we & ~wbAck;
  assign rdStb = wbReq.cyc & wbReq.stb & ~wbReq.we & ~wbAck;
  assign ctlWr = wrStb & (wbReq.adr == `ADDR_CONTROL) & wbReq.sel[0];

  // ---------------------------------------------------------------------------
  // input synchronisers and debounce
  // ---------------------------------------------------------------------------
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
    end else begin
      syncA <= pinsIn;
      syncB <= syncA;
    end
  end

  // filter length shared by the three pulse inputs; phases only slow encoders
  logic [2:0] clean;
  logic [2:0] cleanQ;
  logic [3:0] bounceCnt [3];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clean <= 3'h0;
      for (int i = 0; i < 3; i++) bounceCnt[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (syncB[4-i] == clean[2-i]) begin
          bounceCnt[i] <= 4'h0;
        end else if (bounceCnt[i] == 4'(`DEBOUNCE_CYCLES - 1)) begin
          clean[2-i]   <= syncB[4-i];
          bounceCnt[i] <= 4'h0;
        end else begin
          bounceCnt[i] <= bounceCnt[i] + 4'h1;
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cleanQ <= 3'h0;
    else        cleanQ <= clean;
  end

  // ---------------------------------------------------------------------------
  // encoder decode and position
  // ---------------------------------------------------------------------------
  logic encA;
  logic encB;
  logic encAq;
  logic encBq;
  assign encA  = config_[`CFG_INVERT_DIR] ? clean[1] : clean[2];
  assign encB  = config_[`CFG_INVERT_DIR] ? clean[2] : clean[1];
  assign encAq = config_[`CFG_INVERT_DIR] ? cleanQ[1] : cleanQ[2];
  assign encBq = config_[`CFG_INVERT_DIR] ? cleanQ[2] : cleanQ[1];

  logic       quadStep;
  logic       quadUp;
  logic       uniStep;
  assign quadStep = (encA ^ encAq) | (encB ^ encBq);
  assign quadUp   = (encA ^ encAq) ? (encA ^ encB) : ~(encA ^ encB);
  assign uniStep  = clean[2] & ~cleanQ[2];

  logic [15:0] rateTick;
  logic [31:0] rateAcc;
  logic        rateStep;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rateTick <= 16'h0000;
      rateAcc  <= 32'h0;
    end else if (rateTick == 16'(`RATE_TICK_CYCLES - 1)) begin
      rateTick <= 16'h0000;
      // accumulates mm/s times pulses/mm per microsecond tick
      rateAcc  <= rateAcc + 32'(lineSpeed) * 32'(resolution);
    end else begin
      rateTick <= rateTick + 16'h0001;
      if (rateStep) rateAcc <= rateAcc - 32'd1000000;
    end
  end
  assign rateStep = (rateAcc >= 32'd1000000) && (rateTick != 16'(`RATE_TICK_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      position <= 32'sh0;
    end else if (config_[`CFG_ENCODERLESS]) begin
      if (rateStep) position <= position + 32'sh1;
    end else if (config_[`CFG_QUADRATURE]) begin
      if (quadStep) position <= quadUp ? position + 32'sh1 : position - 32'sh1;
    end else if (uniStep) begin
      position <= position + 32'sh1;
    end
  end

  // micrometres travelled since part sense; divide is slow but rarely needed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) distance <= 32'h0;
    // restart at part sense, else the last part's stale count can hit the offset at once
    else if (partEdge && !markBusy) distance <= 32'h0;
    else        distance <= 32'((64'(position - startPos) * 64'd1000) / 64'(resolution));
  end

  // ---------------------------------------------------------------------------
  // part trigger and mark tracking
  // ---------------------------------------------------------------------------
  assign partEdge = config_[`CFG_RISING_EDGE] ? (clean[0] & ~cleanQ[0])
                                              : (~clean[0] & cleanQ[0]);
  logic armed;
  logic markHit;
  assign markHit = armed && (distance >= sensorOfs);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      markBusy  <= 1'b0;
      armed     <= 1'b0;
      startPos  <= 32'sh0;
      markStart <= 1'b0;
    end else begin
      markStart <= markHit;
      if (partEdge && !markBusy) begin
        startPos <= position;
        armed    <= 1'b1;
        markBusy <= 1'b1;
      end else begin
        if (markHit) armed <= 1'b0;
        if (ctlWr && wbReq.datW[`CTL_MARK_DONE]) markBusy <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // raster settling delay
  // ---------------------------------------------------------------------------
  raster_state_t rasterState;
  logic [15:0]   rasterCnt;
  logic          rasterDone;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rasterState <= RASTER_IDLE;
      rasterCnt   <= 16'h0000;
      rasterOut   <= 1'b0;
      rasterDone  <= 1'b0;
    end else begin
      rasterDone <= 1'b0;
      case (rasterState)
        RASTER_IDLE: begin
          rasterOut <= 1'b0;
          if (ctlWr && wbReq.datW[`CTL_RASTER_GO]) begin
            rasterCnt   <= rasterDly;
            rasterState <= RASTER_SETTLE;
          end
        end
        RASTER_SETTLE: begin
          if (rasterCnt == 16'h0000) begin
            rasterOut   <= 1'b1;
            rasterState <= RASTER_OUT;
          end else begin
            rasterCnt <= rasterCnt - 16'h0001;
          end
        end
        RASTER_OUT: begin
          rasterOut   <= 1'b0;
          rasterDone  <= 1'b1;
          rasterState <= RASTER_IDLE;
        end
        default: rasterState <= RASTER_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // laser output and configurable output
  // ---------------------------------------------------------------------------
  logic        laserReq;
  logic [11:0] pwmCnt;
  logic [31:0] scaled;
  logic [11:0] duty;
  assign scaled = (32'(power) * 32'(powerAdj)) / 32'(`POWER_ADJ_UNITY);
  assign duty   = (scaled > 32'(`PWM_PERIOD)) ? `PWM_PERIOD : scaled[11:0];
  logic fireOk;
  assign fireOk = laserReq & (~config_[`CFG_INTERLOCK_EN] | syncB[1]);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      laserReq <= 1'b0;
      pwmCnt   <= 12'h000;
      pinsOut  <= 2'b00;
    end else begin
      if (ctlWr) laserReq <= wbReq.datW[`CTL_LASER_REQ];
      pwmCnt <= (pwmCnt == `PWM_PERIOD - 12'h001) ? 12'h000 : pwmCnt + 12'h001;
      if (config_[`CFG_PWM_MODE])
        pinsOut.laserOut <= fireOk & (pwmCnt < duty);
      else
        pinsOut.laserOut <= fireOk;
      pinsOut.configurableOutput <= config_[`CFG_OUT_REMAP] ? syncB[0]
                                                            : config_[`CFG_HOST_OUT];
    end
  end

  // ---------------------------------------------------------------------------
  // wishbone slave, status and interrupt
  // ---------------------------------------------------------------------------
  logic [3:0] events;
  logic       stRead;
  assign events = {markHit, rasterDone, partEdge & markBusy, partEdge & ~markBusy};
  assign stRead = rdStb && (wbReq.adr == `ADDR_STATUS);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) status <= 4'h0;
    else        status <= (stRead ? 4'h0 : status) | events;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else        irq <= |(status & mask);
  end

  function automatic logic [15:0] clip_trim(input logic [15:0] v);
    logic signed [15:0] s;
    s = v;
    if (s > `TRIM_LIMIT)       return `TRIM_LIMIT;
    else if (s < -`TRIM_LIMIT) return -`TRIM_LIMIT;
    else                       return v;
  endfunction : clip_trim

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_    <= `CFG_RESET;
      power      <= 16'h0000;
      powerAdj   <= `POWER_ADJ_RESET;
      motion     <= 16'h0000;
      trim       <= 16'sh0000;
      sensorOfs  <= 32'h0;
      resolution <= `RESOLUTION_RESET;
      lineSpeed  <= 16'h0000;
      rasterDly  <= 16'h0000;
      mask       <= 4'h0;
    end else if (wrStb) begin
      if (wbReq.adr == `ADDR_CONFIG) begin
        if (wbReq.sel[0]) config_ <= wbReq.datW[7:0];
      end else if (wbReq.adr == `ADDR_POWER) begin
        if (wbReq.sel[0]) power <= wbReq.datW[15:0];
      end else if (wbReq.adr == `ADDR_POWER_ADJ) begin
        if (wbReq.sel[0]) powerAdj <= wbReq.datW[15:0];
      end else if (wbReq.adr == `ADDR_MOTION) begin
        if (wbReq.sel[0] && wbReq.datW[15:0] <= `MOTION_MAX) motion <= wbReq.datW[15:0];
      end else if (wbReq.adr == `ADDR_TRIM) begin
        if (wbReq.sel[0]) trim <= clip_trim(wbReq.datW[15:0]);
      end else if (wbReq.adr == `ADDR_SENSOR_OFS) begin
        if (wbReq.sel[0]) sensorOfs <= wbReq.datW;
      end else if (wbReq.adr == `ADDR_RESOLUTION) begin
        if (wbReq.sel[0] && wbReq.datW[15:0] != 16'h0000) resolution <= wbReq.datW[15:0];
      end else if (wbReq.adr == `ADDR_LINE_SPEED) begin
        if (wbReq.sel[0]) lineSpeed <= wbReq.datW[15:0];
      end else if (wbReq.adr == `ADDR_RASTER_DLY) begin
        if (wbReq.sel[0]) rasterDly <= wbReq.datW[15:0];
      end else if (wbReq.adr == `ADDR_MASK) begin
        if (wbReq.sel[0]) mask <= wbReq.datW[3:0];
      end
    end
  end

  // single-cycle answer; unmapped addresses read zero and ignore writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbAck  <= 1'b0;
      wbDatR <= 32'h0;
    end else begin
      wbAck  <= wbReq.cyc & wbReq.stb & ~wbAck;
      wbDatR <= 32'h0;
      if (rdStb) begin
        if (wbReq.adr == `ADDR_CONFIG)          wbDatR <= {24'h0, config_};
        else if (wbReq.adr == `ADDR_POWER)      wbDatR <= {16'h0, power};
        else if (wbReq.adr == `ADDR_POWER_ADJ)  wbDatR <= {16'h0, powerAdj};
        else if (wbReq.adr == `ADDR_MOTION)     wbDatR <= {16'h0, motion};
        else if (wbReq.adr == `ADDR_TRIM)       wbDatR <= {{16{trim[15]}}, trim};
        else if (wbReq.adr == `ADDR_SENSOR_OFS) wbDatR <= sensorOfs;
        else if (wbReq.adr == `ADDR_RESOLUTION) wbDatR <= {16'h0, resolution};
        else if (wbReq.adr == `ADDR_LINE_SPEED) wbDatR <= {16'h0, lineSpeed};
        else if (wbReq.adr == `ADDR_RASTER_DLY) wbDatR <= {16'h0, rasterDly};
        else if (wbReq.adr == `ADDR_POSITION)   wbDatR <= position;
        else if (wbReq.adr == `ADDR_STATUS)     wbDatR <= {28'h0, status};
        else if (wbReq.adr == `ADDR_MASK)       wbDatR <= {28'h0, mask};
        else if (wbReq.adr == `ADDR_CONTROL)    wbDatR <= {30'h0, laserReq, markBusy};
        else if (wbReq.adr == `ADDR_DISTANCE)   wbDatR <= distance;
      end
    end
  end
endmodule : part_tracking_encoder_control

/* File: dv/part_track_asserts.sv */
// port checker of the part tracking block
// assumes a bind to the design top; config is shadowed from bus writes
`timescale 1ns/1ps
`include "part_track_map.svh"
module part_track_asserts (
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  input wire part_track_pkg::wb_req_t   wbReq,
  input wire logic [31:0]               wbDatR,
  input wire logic                      wbAck,
  input wire part_track_pkg::pins_in_t  pinsIn,
  input wire part_track_pkg::pins_out_t pinsOut,
  input wire logic                      markStart,
  input wire logic                      rasterOut,
  input wire logic                      irq
);
  import part_track_pkg::*;
  // ---------------------------------------------------------------------------
  // config shadow
  // ---------------------------------------------------------------------------
  logic [7:0] cfg;
  logic       laserReq;
  logic [1:0] age;
  wire        wrHit = wbAck && wbReq.we && wbReq.sel[0];
  // age holds checks off while a new setting ripples to the pins
  wire        settled = (age == 2'h3);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `CFG_RESET;
      laserReq <= 1'b0;
      age <= 2'h0;
    end else if (wrHit && (wbReq.adr == `ADDR_CONFIG)) begin
      cfg <= wbReq.datW[7:0];
      age <= 2'h0;
    end else if (wrHit && (wbReq.adr == `ADDR_CONTROL)) begin
      laserReq <= wbReq.datW[`CTL_LASER_REQ];
      age <= 2'h0;
    end else if (!settled) begin
      age <= age + 2'h1;
    end
  end
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  chk_ack_follows: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("request not answered in one cycle");
  chk_rdata_idle: assert property (!wbAck |-> wbDatR == 32'h0)
    else $error("read data not zero outside ack");
  chk_interlock_gate: assert property ((settled && cfg[`CFG_INTERLOCK_EN]) ##0
    (!pinsIn.interlockInput) [*4] |=> !pinsOut.laserOut)
    else $error("laser on with interlock input low");
  chk_gate_full: assert property (settled && !cfg[`CFG_INTERLOCK_EN] &&
    !cfg[`CFG_PWM_MODE] && laserReq |-> pinsOut.laserOut)
    else $error("gate mode laser not fully on");
  chk_host_out: assert property (settled && !cfg[`CFG_OUT_REMAP] |->
    pinsOut.configurableOutput == cfg[`CFG_HOST_OUT])
    else $error("output does not follow host command");
  chk_temp_warn: assert property ((settled && cfg[`CFG_OUT_REMAP]) ##0
    pinsIn.overTemp [*4] |=> pinsOut.configurableOutput)
    else $error("over temperature warning missing");
  chk_raster_pulse: assert property (rasterOut |=> !rasterOut)
    else $error("raster output longer than a pulse");
endmodule : part_track_asserts
bind part_tracking_encoder_control part_track_asserts part_track_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .wbReq(wbReq), .wbDatR(wbDatR),
  .wbAck(wbAck), .pinsIn(pinsIn), .pinsOut(pinsOut), .markStart(markStart),
  .rasterOut(rasterOut), .irq(irq));

/* File: dv/conveyor_sensor_model.sv */
// conveyor encoder and part sensor facing the head
// assumes core_clk pacing; lines hold their level while the belt stands
`timescale 1ns/1ps
module conveyor_sensor_model (
  input  wire logic core_clk,
  output logic      phaseA,
  output logic      phaseB,
  output logic      partSense
);
  logic [1:0] ph;
  initial begin
    ph = 2'h0;
    phaseA = 1'b0;
    phaseB = 1'b0;
    partSense = 1'b0;
  end
  // each state outlasts the input filter, so no step is lost
  task automatic move(input int steps, input bit rev, input bit quad);
    repeat (steps) begin
      @(posedge core_clk);
      if (quad) begin
        ph = rev ? ph - 2'h1 : ph + 2'h1;
        phaseA <= ph[0] ^ ph[1];
        phaseB <= ph[1];
      end else begin
        phaseA <= ~phaseA;
      end
      repeat (12) @(posedge core_clk);
    end
  endtask : move
  task automatic sense(input logic lvl);
    @(posedge core_clk);
    partSense <= lvl;
    repeat (20) @(posedge core_clk);
  endtask : sense
endmodule : conveyor_sensor_model

/* File: dv/test_part_tracking_encoder_control.sv */
// testbench of the part tracking block
// assumes the checker binds itself; model drives encoder and sensor
`timescale 1ns/1ps
`include "part_track_map.svh"
module test_part_tracking_encoder_control;
  import part_track_pkg::*;
  logic        core_clk, rst_n, hot, ilk, mA, mB, mS, wbAck, markStart, rasterOut, irq;
  logic [31:0] wbDatR, q, p;
  wb_req_t     wbReq;
  pins_in_t    pinsIn;
  pins_out_t   pinsOut;
  int          errors, totalChecks, n, h, i, marks;
  int          cycles = 0;
  assign pinsIn = '{phaseA: mA, phaseB: mB, partSense: mS, interlockInput: ilk, overTemp: hot};
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  part_tracking_encoder_control part_tracking_encoder_control_inst (
    .core_clk(core_clk), .rst_n(rst_n), .wbReq(wbReq), .wbDatR(wbDatR), .wbAck(wbAck),
    .pinsIn(pinsIn), .pinsOut(pinsOut), .markStart(markStart), .rasterOut(rasterOut),
    .irq(irq));
  conveyor_sensor_model conveyor_sensor_model_inst (
    .core_clk(core_clk), .phaseA(mA), .phaseB(mB), .partSense(mS));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wbReq <= '{adr: a, datW: d, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    check("ack", wbAck, 1'b1);
    q = wbDatR;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask : tick
  // laser-on cycles over 4096 cycles, one 4095-cycle pwm period plus one
  task automatic duty();
    h = 0;
    repeat (4096) begin
      @(posedge core_clk);
      h += pinsOut.laserOut;
    end
  endtask : duty
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge core_clk) begin
    cycles++;
    marks += markStart;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wbReq = '0;
    hot = 1'b0;
    ilk = 1'b0;
    errors = 0;
    totalChecks = 0;
    tick(20);
    rst_n <= 1'b1;
    rd(`ADDR_CONFIG); check("config", q, {24'h0, `CFG_RESET});
    rd(`ADDR_POWER_ADJ); check("power adj", q, {16'h0, `POWER_ADJ_RESET});
    wr(`ADDR_RESOLUTION, 32'h0); rd(`ADDR_RESOLUTION); check("res", q, 32'h1);
    wr(8'h3c, 32'hffffffff); rd(8'h3c); check("unmapped", q, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(`ADDR_MOTION, i * 90); rd(`ADDR_MOTION); check("motion", q, i * 90);
    end
    wr(`ADDR_MOTION, 32'h168); rd(`ADDR_MOTION); check("motion 360", q, 32'h10e);
    wr(`ADDR_TRIM, 32'h7d0); rd(`ADDR_TRIM); check("trim hi", q[15:0], 16'h5dc);
    wr(`ADDR_TRIM, 32'hfffff830); rd(`ADDR_TRIM); check("trim lo", q[15:0], 16'hfa24);
    $display("registers done");
    wr(`ADDR_CONFIG, 32'h80); tick(6); check("host out", pinsOut.configurableOutput, 1);
    wr(`ADDR_CONFIG, 32'h84); hot <= 1'b1; tick(6);
    check("warn on", pinsOut.configurableOutput, 1'b1);
    hot <= 1'b0; tick(6); check("warn off", pinsOut.configurableOutput, 1'b0);
    wr(`ADDR_CONTROL, 32'h4); wr(`ADDR_CONFIG, 32'h0); tick(6);
    check("gate", pinsOut.laserOut, 1'b1);
    wr(`ADDR_CONFIG, 32'h1); tick(6); check("interlock low", pinsOut.laserOut, 1'b0);
    ilk <= 1'b1; tick(6); check("interlock high", pinsOut.laserOut, 1'b1);
    wr(`ADDR_CONFIG, 32'h2); wr(`ADDR_POWER, 32'h800); duty();
    check("pwm", h > 0 && h < 4096, 1'b1);
    wr(`ADDR_POWER_ADJ, 32'h0); duty(); check("scaled", h, 32'h0);
    wr(`ADDR_POWER_ADJ, 32'h3e8); wr(`ADDR_CONTROL, 32'h0);
    $display("outputs done");
    wr(`ADDR_CONFIG, 32'h10); conveyor_sensor_model_inst.move(8, 0, 1); tick(10);
    rd(`ADDR_POSITION); p = q; check("fwd", p != 0, 1'b1);
    conveyor_sensor_model_inst.move(8, 1, 1); tick(10);
    rd(`ADDR_POSITION); check("back", q, 32'h0);
    wr(`ADDR_CONFIG, 32'h30); conveyor_sensor_model_inst.move(8, 0, 1); tick(10);
    rd(`ADDR_POSITION); check("invert", q, -p);
    conveyor_sensor_model_inst.move(8, 1, 1); wr(`ADDR_CONFIG, 32'h0);
    conveyor_sensor_model_inst.move(4, 0, 0); tick(10); rd(`ADDR_POSITION); p = q;
    conveyor_sensor_model_inst.move(4, 1, 0); tick(10); rd(`ADDR_POSITION);
    check("single", q == 2 * p && p != 0, 1'b1);
    wr(`ADDR_RESOLUTION, 32'h3e8); wr(`ADDR_LINE_SPEED, 32'h3e8);
    wr(`ADDR_CONFIG, 32'h40); rd(`ADDR_POSITION); p = q; tick(4000);
    rd(`ADDR_POSITION); check("encoderless", q != p, 1'b1);
    $display("encoder done");
    wr(`ADDR_CONFIG, 32'h8); wr(`ADDR_MASK, 32'h2); rd(`ADDR_STATUS);
    conveyor_sensor_model_inst.sense(1'b1); check("masked", irq, 1'b0);
    rd(`ADDR_STATUS); check("rise", q[0], 1'b1);
    conveyor_sensor_model_inst.sense(1'b0); rd(`ADDR_STATUS);
    check("fall ignored", q[1:0], 2'h0);
    conveyor_sensor_model_inst.sense(1'b1); check("irq", irq, 1'b1);
    rd(`ADDR_STATUS); check("missed", q[1], 1'b1);
    tick(3); check("irq clear", irq, 1'b0);
    wr(`ADDR_CONTROL, 32'h1); wr(`ADDR_CONFIG, 32'h0);
    conveyor_sensor_model_inst.sense(1'b0); rd(`ADDR_STATUS); check("fall", q[0], 1'b1);
    $display("part sense done");
    wr(`ADDR_RESOLUTION, 32'h1); wr(`ADDR_SENSOR_OFS, 32'h7d0); wr(`ADDR_CONTROL, 32'h1);
    conveyor_sensor_model_inst.move(4, 0, 0); wr(`ADDR_CONFIG, 32'h8); p = marks;
    conveyor_sensor_model_inst.sense(1'b1); conveyor_sensor_model_inst.move(1, 0, 0);
    tick(4); rd(`ADDR_DISTANCE); check("distance", q, 32'd1000);
    check("mark early", marks - p, 32'd0);
    conveyor_sensor_model_inst.move(2, 0, 0); tick(4); check("mark", marks - p, 32'd1);
    $display("offset done");
    wr(`ADDR_RASTER_DLY, 32'ha); wr(`ADDR_CONTROL, 32'h2); n = 0;
    while (rasterOut !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    check("raster", n >= 9 && n < 200, 1'b1);
    rd(`ADDR_STATUS); check("raster done", q[2], 1'b1);
    $display("raster done");
    end_of_test();
  end
endmodule : test_part_tracking_encoder_control
